// *** core/sfpe_host.sv ***
`timescale 1ns/1ps
// Contract
// - write enable is sent before chip erase; device erases only with latch set.
// - chip erase is a lone opcode, 60 or c7, framed by chip select.
// - page program opcode 02 follows write enable; bits go to zero.
// - host frames opcode, three address bytes, at least one data byte.
// - chip select rises only after a whole data byte, else rejected.
// - dual program a2 carries data two bits per clock on lines 0-1.
// - quad program 32 needs latch and quad enable; data on four lines.
// - quad program sends opcode and address on line 0 only.
// - security erase 44 follows write enable, sends a 24-bit address.
// - security erase chip select rises on a byte boundary only.
// - security program 42 follows write enable, 1 to 256/512 bytes.
module sfpe_host #(
    parameter logic [7:0] STATUS_OPCODE = 8'h05,
    parameter int         FL_BUSY_BIT   = 0
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire sfpe_pkg::sfpe_wb_req_t wb_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       flash_cs_n,
    output logic                       flash_sck,
    output logic [3:0]                 io_out,
    output logic [3:0]                 io_oe,
    input  wire logic [3:0]            io_in
);

    typedef enum logic [2:0] {S_IDLE, S_LOAD, S_LOW, S_HIGH, S_GAP} sfpe_st_t;

    sfpe_st_t             state;
    sfpe_pkg::sfpe_frame_t frame;
    sfpe_pkg::sfpe_kind_t  kind;
    logic [1:0]  region;
    logic        poll_en;
    logic [23:0] addr;
    logic [9:0]  count;
    logic        err;
    logic        start_pend;
    logic [7:0]  last_status;
    logic [7:0]  buf_mem [0:511];
    logic [3:0]  div_cnt;
    logic [3:0]  gap_cnt;
    logic [7:0]  sh;
    logic [3:0]  bits_left;
    logic [9:0]  byte_idx;
    logic [7:0]  rd;
    logic        io1_meta;
    logic        io1_sync;

    // bus decode
    wire wb_hit  = wb_i.cyc && wb_i.stb && !wb_ack_o;
    wire wr_en   = wb_hit && wb_i.we;
    wire is_buf  = wb_i.adr[sfpe_pkg::BUF_SEL_BIT];
    wire [8:0] buf_idx = wb_i.adr[10:2];
    wire busy    = (state != S_IDLE);
    // writes to registers are dropped while a sequence runs
    wire reg_wr  = wr_en && !busy && !is_buf;
    wire wr_ctrl = reg_wr && (wb_i.adr == sfpe_pkg::REG_CTRL);
    wire wr_addr = reg_wr && (wb_i.adr == sfpe_pkg::REG_ADDR);
    wire wr_cnt  = reg_wr && (wb_i.adr == sfpe_pkg::REG_COUNT);
    wire wr_buf  = wr_en && !busy && is_buf && wb_i.sel[0];
    wire go_req  = wr_ctrl && wb_i.sel[1] && wb_i.dat[sfpe_pkg::CTRL_GO_BIT];

    // command properties
    wire is_ce   = (kind == sfpe_pkg::K_CE_60) || (kind == sfpe_pkg::K_CE_C7);
    wire is_otp  = (kind == sfpe_pkg::K_OTP_ER) || (kind == sfpe_pkg::K_OTP_PR);
    wire has_data = (kind == sfpe_pkg::K_PROG) ||
                    (kind == sfpe_pkg::K_PROG2) ||
                    (kind == sfpe_pkg::K_PROG4) || (kind == sfpe_pkg::K_OTP_PR);
    wire data_ok = !has_data ||
                   ((count != 10'h000) && (count <= sfpe_pkg::MAX_COUNT));
    wire args_ok = (kind != sfpe_pkg::K_NONE) && data_ok &&
                   (!is_otp || (region != 2'h0));
    wire [23:0] hdr_addr = is_otp ?
        {sfpe_pkg::OTP_TOP, 2'h0, region, sfpe_pkg::OTP_MID, addr[8:0]} :
        addr;
    wire [9:0] cmd_len = is_ce ? 10'h001 :
                         has_data ? sfpe_pkg::HDR_BYTES + count :
                         sfpe_pkg::HDR_BYTES;
    wire [9:0] frame_len = (frame == sfpe_pkg::FR_WR_EN) ? 10'h001 :
                           (frame == sfpe_pkg::FR_POLL) ? 10'h002 : cmd_len;

    function automatic logic [7:0] kind_op(input sfpe_pkg::sfpe_kind_t k);
        unique case (k)
            sfpe_pkg::K_CE_60:  kind_op = sfpe_pkg::OP_CE_A;
            sfpe_pkg::K_CE_C7:  kind_op = sfpe_pkg::OP_CE_B;
            sfpe_pkg::K_PROG:   kind_op = sfpe_pkg::OP_PROG;
            sfpe_pkg::K_PROG2:  kind_op = sfpe_pkg::OP_PROG2;
            sfpe_pkg::K_PROG4:  kind_op = sfpe_pkg::OP_PROG4;
            sfpe_pkg::K_OTP_ER: kind_op = sfpe_pkg::OP_OTP_ER;
            sfpe_pkg::K_OTP_PR: kind_op = sfpe_pkg::OP_OTP_PR;
            sfpe_pkg::K_NONE:   kind_op = 8'h00;
        endcase
    endfunction : kind_op

    // byte selection for the frame in flight
    wire [9:0] data_pos = byte_idx - sfpe_pkg::HDR_BYTES;
    wire in_data = (frame == sfpe_pkg::FR_CMD) &&
                   (byte_idx >= sfpe_pkg::HDR_BYTES);
    wire [7:0] cmd_byte = (byte_idx == 10'h000) ? kind_op(kind) :
                          (byte_idx == 10'h001) ? hdr_addr[23:16] :
                          (byte_idx == 10'h002) ? hdr_addr[15:8] :
                          (byte_idx == 10'h003) ? hdr_addr[7:0] :
                          buf_mem[data_pos[8:0]];
    wire [7:0] cur_byte = (frame == sfpe_pkg::FR_WR_EN) ? sfpe_pkg::OP_WR_EN :
                          (frame == sfpe_pkg::FR_POLL) ?
                          ((byte_idx == 10'h000) ? STATUS_OPCODE : 8'h00) :
                          cmd_byte;
    // header bytes always go out one bit per clock on line 0
    wire [2:0] cur_lanes = (in_data && kind == sfpe_pkg::K_PROG4) ? 3'h4 :
                           (in_data && kind == sfpe_pkg::K_PROG2) ? 3'h2 :
                           3'h1;
    wire is_rd_byte = (frame == sfpe_pkg::FR_POLL) && (byte_idx == 10'h001);
    wire [3:0] next_io = (cur_lanes == 3'h4) ? sh[7:4] :
                         (cur_lanes == 3'h2) ? {2'h3, sh[7:6]} :
                         is_rd_byte ? 4'hc : {3'h6, sh[7]};
    // io1 is left to the flash in single-line mode; io2/io3 held high
    wire [3:0] next_oe = (cur_lanes == 3'h1) ? 4'hd : 4'hf;
    wire tick      = (div_cnt == 4'(sfpe_pkg::SCK_HALF_CYC - 1));
    wire gap_done  = (gap_cnt == 4'(sfpe_pkg::CS_GAP_CYC - 1));
    wire last_bits = (bits_left == {1'b0, cur_lanes});
    wire last_byte = (byte_idx == frame_len - 10'h001);
    wire poll_busy = rd[FL_BUSY_BIT];

    wire [31:0] ctrl_word = {22'h0, poll_en, 3'h0, region, 1'b0, kind};
    wire [31:0] stat_word = {16'h0, last_status, 5'h0,
                             last_status[FL_BUSY_BIT],
                             err, busy};
    wire [31:0] rd_word =
        is_buf ? {24'h0, buf_mem[buf_idx]} :
        (wb_i.adr == sfpe_pkg::REG_CTRL)   ? ctrl_word :
        (wb_i.adr == sfpe_pkg::REG_ADDR)   ? {8'h0, addr} :
        (wb_i.adr == sfpe_pkg::REG_COUNT)  ? {22'h0, count} :
        (wb_i.adr == sfpe_pkg::REG_STATUS) ? stat_word : 32'h0;

    // the pin crosses from the flash side; only io1 is ever read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io1_meta <= 1'b0;
            io1_sync <= 1'b0;
        end else begin
            io1_meta <= io_in[1];
            io1_sync <= io1_meta;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_buf) begin
            buf_mem[buf_idx] <= wb_i.dat[7:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kind    <= sfpe_pkg::K_NONE;
            region  <= 2'h0;
            poll_en <= 1'b0;
            addr    <= 24'h0;
            count   <= 10'h0;
        end else begin
            if (wr_ctrl && wb_i.sel[0]) begin
                kind   <= sfpe_pkg::sfpe_kind_t'(wb_i.dat[2:0]);
                region <= wb_i.dat[sfpe_pkg::CTRL_REGION_LSB +: 2];
            end
            if (wr_ctrl && wb_i.sel[1]) begin
                poll_en <= wb_i.dat[sfpe_pkg::CTRL_POLL_BIT];
            end
            if (wr_addr && wb_i.sel[0]) addr[7:0]   <= wb_i.dat[7:0];
            if (wr_addr && wb_i.sel[1]) addr[15:8]  <= wb_i.dat[15:8];
            if (wr_addr && wb_i.sel[2]) addr[23:16] <= wb_i.dat[23:16];
            if (wr_cnt && wb_i.sel[0]) count[7:0] <= wb_i.dat[7:0];
            if (wr_cnt && wb_i.sel[1]) count[9:8] <= wb_i.dat[9:8];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state       <= S_IDLE;
            frame       <= sfpe_pkg::FR_WR_EN;
            start_pend  <= 1'b0;
            err         <= 1'b0;
            last_status <= 8'h0;
            flash_cs_n  <= 1'b1;
            flash_sck   <= 1'b0;
            io_out      <= 4'hc;
            io_oe       <= 4'hc;
            div_cnt     <= 4'h0;
            gap_cnt     <= 4'h0;
            sh          <= 8'h0;
            bits_left   <= 4'h0;
            byte_idx    <= 10'h0;
            rd          <= 8'h0;
        end else begin
            start_pend <= go_req;
            unique case (state)
                S_IDLE: if (start_pend) begin
                    err <= !args_ok;
                    if (args_ok) begin
                        frame      <= sfpe_pkg::FR_WR_EN;
                        flash_cs_n <= 1'b0;
                        byte_idx   <= 10'h0;
                        state      <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    sh        <= cur_byte;
                    bits_left <= 4'h8;
                    div_cnt   <= 4'h0;
                    state     <= S_LOW;
                end
                S_LOW: begin
                    io_out  <= next_io;
                    io_oe   <= next_oe;
                    div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
                    if (tick) begin
                        flash_sck <= 1'b1;
                        state     <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
                    if (tick) begin
                        flash_sck <= 1'b0;
                        rd        <= {rd[6:0], io1_sync};
                        sh        <= sh << cur_lanes;
                        bits_left <= bits_left - {1'b0, cur_lanes};
                        if (!last_bits) begin
                            state <= S_LOW;
                        end else if (last_byte) begin
                            // release only on a whole byte
                            flash_cs_n <= 1'b1;
                            gap_cnt    <= 4'h0;
                            state      <= S_GAP;
                        end else begin
                            byte_idx <= byte_idx + 10'h001;
                            state    <= S_LOAD;
                        end
                    end
                end
                S_GAP: begin
                    io_out  <= 4'hc;
                    io_oe   <= 4'hc;
                    gap_cnt <= gap_cnt + 4'h1;
                    if (gap_done) begin
                        byte_idx <= 10'h0;
                        state    <= S_IDLE;
                        unique case (frame)
                            sfpe_pkg::FR_WR_EN: begin
                                frame      <= sfpe_pkg::FR_CMD;
                                flash_cs_n <= 1'b0;
                                state      <= S_LOAD;
                            end
                            sfpe_pkg::FR_CMD: if (poll_en) begin
                                frame      <= sfpe_pkg::FR_POLL;
                                flash_cs_n <= 1'b0;
                                state      <= S_LOAD;
                            end
                            sfpe_pkg::FR_POLL: begin
                                last_status <= rd;
                                // next write only once the flash is idle
                                if (poll_busy) begin
                                    flash_cs_n <= 1'b0;
                                    state      <= S_LOAD;
                                end
                            end
                            default: state <= S_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // helper state for the checks below
    logic [12:0] bit_cnt;
    logic        wr_en_done;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt    <= 13'h0;
            wr_en_done <= 1'b0;
        end else begin
            if (flash_cs_n && state == S_IDLE) bit_cnt <= 13'h0;
            else if (state == S_LOAD && byte_idx == 10'h0) bit_cnt <= 13'h0;
            else if (state == S_HIGH && tick)
                bit_cnt <= bit_cnt + {10'h0, cur_lanes};
            if (state == S_GAP && frame == sfpe_pkg::FR_WR_EN)
                wr_en_done <= 1'b1;
            else if (state == S_IDLE) wr_en_done <= 1'b0;
        end
    end

    wire [12:0] data_bits = {count, 3'h0} + 13'h020;

    sequence cmd_release;
        $rose(flash_cs_n) && frame == sfpe_pkg::FR_CMD;
    endsequence

    chk_write_enable_cmd_first: assert property (@(posedge clk) disable iff (!nrst)
        $fell(flash_cs_n) && frame == sfpe_pkg::FR_CMD |-> wr_en_done)
        else $error("command frame without prior write enable");

    chk_ce_lone_op: assert property (@(posedge clk) disable iff (!nrst)
        cmd_release and is_ce |-> bit_cnt == 13'h008)
        else $error("chip erase frame not exactly one byte");

    chk_byte_edge: assert property (@(posedge clk) disable iff (!nrst)
        $rose(flash_cs_n) |-> bit_cnt[2:0] == 3'h0 && bit_cnt != 13'h0)
        else $error("chip select released mid-byte");

    chk_prog_length: assert property (@(posedge clk) disable iff (!nrst)
        cmd_release and has_data |-> bit_cnt == data_bits)
        else $error("program frame length differs from header plus count");

    chk_otp_er_len: assert property (@(posedge clk) disable iff (!nrst)
        cmd_release and kind == sfpe_pkg::K_OTP_ER |-> bit_cnt == 13'h020)
        else $error("security erase frame not opcode plus address");

    chk_quad_header: assert property (@(posedge clk) disable iff (!nrst)
        $rose(flash_sck) && frame == sfpe_pkg::FR_CMD &&
        kind == sfpe_pkg::K_PROG4 |->
        (byte_idx < sfpe_pkg::HDR_BYTES) == (io_oe == 4'hd))
        else $error("quad header not single line or data not on four");

    chk_dual_lanes: assert property (@(posedge clk) disable iff (!nrst)
        $rose(flash_sck) && in_data && kind == sfpe_pkg::K_PROG2 |->
        io_oe == 4'hf && io_out[3:2] == 2'h3)
        else $error("dual data not driven on two lines");

    chk_otp_address: assert property (@(posedge clk) disable iff (!nrst)
        $fell(flash_cs_n) && frame == sfpe_pkg::FR_CMD && is_otp |->
        hdr_addr[23:16] == 8'h00 && hdr_addr[11:9] == 3'h0 &&
        hdr_addr[15:12] != 4'h0)
        else $error("security region address malformed");

    chk_cs_gap: assert property (@(posedge clk) disable iff (!nrst)
        $rose(flash_cs_n) |-> flash_cs_n [*8])
        else $error("chip select high gap too short");

endmodule : sfpe_host

// *** inc/sfpe_pkg.sv ***
package sfpe_pkg;

    // flash opcodes driven by this controller
    localparam logic [7:0] OP_WR_EN  = 8'h06;
    localparam logic [7:0] OP_CE_A   = 8'h60;
    localparam logic [7:0] OP_CE_B   = 8'hc7;
    localparam logic [7:0] OP_PROG   = 8'h02;
    localparam logic [7:0] OP_PROG2  = 8'ha2;
    localparam logic [7:0] OP_PROG4  = 8'h32;
    localparam logic [7:0] OP_OTP_ER = 8'h44;
    localparam logic [7:0] OP_OTP_PR = 8'h42;

    // wishbone register map, byte addresses
    localparam int         ADR_W      = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_ADDR   = 12'h004;
    localparam logic [11:0] REG_COUNT  = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam int         BUF_SEL_BIT = 11;

    // field positions
    localparam int CTRL_KIND_LSB   = 0;
    localparam int CTRL_REGION_LSB = 4;
    localparam int CTRL_GO_BIT     = 8;
    localparam int CTRL_POLL_BIT   = 9;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_ERR_BIT    = 1;
    localparam int STAT_FL_BUSY_BIT = 2;
    localparam int STAT_BYTE_LSB   = 8;

    // sizes
    localparam logic [9:0] HDR_BYTES = 10'h004;
    localparam logic [9:0] MAX_COUNT = 10'h200;
    localparam logic [7:0] OTP_TOP   = 8'h00;
    localparam logic [2:0] OTP_MID   = 3'h0;

    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCK_HALF_NS   = 20;
    localparam int CS_GAP_NS     = 50;
    localparam int SCK_HALF_CYC  =
        (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CS_GAP_CYC    =
        (CS_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        K_CE_60, K_CE_C7, K_PROG, K_PROG2, K_PROG4, K_OTP_ER, K_OTP_PR, K_NONE
    } sfpe_kind_t;

    typedef enum logic [1:0] {FR_WR_EN, FR_CMD, FR_POLL} sfpe_frame_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } sfpe_wb_req_t;

endpackage : sfpe_pkg

// *** verif/sfpe_dev.sv ***
`timescale 1ns/1ps
module sfpe_dev #(
    parameter int         BUSY_NS = 2000,
    parameter logic       QUAD_EN = 1'b1,
    parameter logic [2:0] LOCK    = 3'h0
) (
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic [3:0] io,
    output logic            so_en,
    output logic            so
);
    logic [7:0]  op, acc, st, x_op;
    logic [23:0] adr, x_adr;
    logic        latch = 1'b0;
    logic        in_prog = 1'b0;
    logic [7:0]  page [256];
    logic        ok, go, otp_ok;
    int          nb, w, x_nb;
    int          n_exec  = 0;
    int          n_frame = 0;
    logic [7:0]  got[$];
    logic [7:0]  x_bytes[$];

    initial begin
        so_en = 1'b0;
        so = 1'b0;
        foreach (page[i]) page[i] = 8'hff;
    end
    always @(negedge cs_n) begin
        n_frame++;
        nb = 0;
        op = 8'h00;
        got.delete();
    end
    // header on io0, data width follows the opcode
    always @(posedge sck) if (!cs_n) begin
        w = nb < 32 ? 1 : op == 8'h32 ? 4 : op == 8'ha2 ? 2 : 1;
        for (int i = w - 1; i >= 0; i--) acc = {acc[6:0], io[i]};
        nb += w;
        if (nb == 8) begin
            op = acc;
            st = {6'h00, latch, in_prog};
        end else if (nb % 8 == 0 && nb <= 32) adr = {adr[15:0], acc};
        else if (nb % 8 == 0) got.push_back(acc);
    end
    // status byte moves on the falling edge so it is steady at sampling
    always @(negedge sck) if (!cs_n && op == 8'h05 && nb >= 8) begin
        so_en = 1'b1;
        so = st[7];
        st = {st[6:0], 1'b0};
    end
    always @(posedge cs_n) begin
        so_en = 1'b0;
        go = 1'b0;
        ok = latch && !in_prog && nb % 8 == 0;
        otp_ok = adr[23:16] == 8'h00 && adr[11:9] == 3'h0
            && adr[15:12] inside {[1:3]} && !LOCK[adr[13:12] - 2'd1];
        case (op)
            8'h06: if (nb == 8) latch = 1'b1;
            8'h60, 8'hc7: go = ok && nb == 8;
            8'h02, 8'ha2: go = ok && nb > 32;
            8'h32: go = ok && nb > 32 && QUAD_EN;
            8'h44: go = ok && nb == 32 && otp_ok;
            8'h42: go = ok && nb > 32 && otp_ok;
            default: go = 1'b0;
        endcase
        if (go) begin
            while (got.size() > 256) void'(got.pop_front());
            // page image: wrap inside the page, untouched bytes kept
            if (op inside {8'h02, 8'ha2, 8'h32})
                foreach (got[i]) page[8'(adr[7:0] + i)] &= got[i];
            n_exec++;
            x_op = op;
            x_adr = adr;
            x_nb = nb;
            x_bytes = got;
            in_prog = 1'b1;
            fork
                begin
                    #BUSY_NS;
                    in_prog = 1'b0;
                    latch = 1'b0;
                end
            join_none
        end
    end
endmodule : sfpe_dev

// *** verif/tb_serial_flash_program_erase.sv ***
`timescale 1ns/1ps
module tb_serial_flash_program_erase;
    logic                   clk = 1'b0;
    logic                   nrst;
    sfpe_pkg::sfpe_wb_req_t wb_i;
    logic [31:0]            wb_dat_o, s;
    logic                   wb_ack_o, flash_cs_n, flash_sck, so_en, so;
    logic [3:0]             io_out, io_oe, io_w, m_en, m_v;
    int                     err_count = 0;
    int                     n_checks  = 0;

    // a released line not driven by the device shows the inverse of the host's last level
    assign m_en = {2'b00, so_en, 1'b0};
    assign m_v  = {2'b00, so, 1'b0};
    assign io_w = (io_oe & io_out) | (~io_oe & m_en & m_v)
                | (~io_oe & ~m_en & ~io_out);
    always #2.5 clk = ~clk;

    sfpe_host u_sfpe_host (.clk(clk), .nrst(nrst), .wb_i(wb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_cs_n(flash_cs_n),
        .flash_sck(flash_sck), .io_out(io_out), .io_oe(io_oe), .io_in(io_w));
    sfpe_dev u_sfpe_dev (.cs_n(flash_cs_n), .sck(flash_sck), .io(io_w),
        .so_en(so_en), .so(so));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            finish_test();
        end
        wb_i <= '0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    // go with polling, then wait until the host reports idle
    task automatic cmd(input logic [2:0] k, input logic [1:0] r,
                       input logic [23:0] a, input logic [9:0] c);
        wr(sfpe_pkg::REG_ADDR, {8'h00, a});
        wr(sfpe_pkg::REG_COUNT, {22'h0, c});
        wr(sfpe_pkg::REG_CTRL, {22'h0, 2'b11, 2'b00, r, 1'b0, k});
        for (int i = 0; i < 2000; i++) begin
            wb(1'b0, sfpe_pkg::REG_STATUS, 32'h0, s);
            if (s[0] === 1'b0) break;
        end
        if (s[0] !== 1'b0) begin
            err_count++;
            finish_test();
        end
    endtask : cmd

    task automatic t_reset();
        chk("cs_n", 1, flash_cs_n);
        chk("sck", 0, flash_sck);
        wb(1'b0, 12'h010, 32'h0, s);
        chk("unmapped", 0, s);
        wb(1'b0, sfpe_pkg::REG_STATUS, 32'h0, s);
        chk("status", 0, s);
        $display("test reset done");
    endtask : t_reset

    task automatic t_erase();
        for (int k = 0; k < 2; k++) begin
            int n = u_sfpe_dev.n_exec;
            cmd(3'(k), 2'd0, 24'h0, 10'h0);
            chk("exec", n + 1, u_sfpe_dev.n_exec);
            chk("ce op", k ? 8'hc7 : 8'h60, u_sfpe_dev.x_op);
            chk("ce bits", 8, u_sfpe_dev.x_nb);
            chk("dev status", 0, s[15:8]);
        end
        $display("test erase done");
    endtask : t_erase

    task automatic t_prog();
        logic [7:0] ops [3] = '{8'h02, 8'ha2, 8'h32};
        wr(12'h800, 32'ha5);
        wr(12'h804, 32'h3c);
        wr(12'h808, 32'h0f);
        for (int k = 0; k < 3; k++) begin
            cmd(3'(k + 2), 2'd0, 24'h1234fe, 10'h3);
            chk("prog op", ops[k], u_sfpe_dev.x_op);
            chk("prog adr", 24'h1234fe, u_sfpe_dev.x_adr);
            chk("prog bits", 56, u_sfpe_dev.x_nb);
            chk("prog data", 24'ha53c0f, {u_sfpe_dev.x_bytes[0],
                u_sfpe_dev.x_bytes[1], u_sfpe_dev.x_bytes[2]});
            chk("dev status", 0, s[15:8]);
        end
        chk("page wrap", 32'h0f, u_sfpe_dev.page[0]);
        chk("page keep", 32'hff, u_sfpe_dev.page[1]);
        $display("test program done");
    endtask : t_prog

    task automatic t_otp();
        wr(12'h800, 32'h5a);
        cmd(3'd5, 2'd2, 24'h0001ab, 10'h1);
        chk("er op", 8'h44, u_sfpe_dev.x_op);
        chk("er adr", 24'h0021ab, u_sfpe_dev.x_adr);
        chk("er bits", 32, u_sfpe_dev.x_nb);
        chk("dev status", 0, s[15:8]);
        cmd(3'd6, 2'd3, 24'h0001ff, 10'h1);
        chk("pr op", 8'h42, u_sfpe_dev.x_op);
        chk("pr adr", 24'h0031ff, u_sfpe_dev.x_adr);
        chk("pr data", 8'h5a, u_sfpe_dev.x_bytes[0]);
        chk("dev status", 0, s[15:8]);
        $display("test otp done");
    endtask : t_otp

    task automatic t_refuse();
        int f = u_sfpe_dev.n_frame;
        cmd(3'd2, 2'd0, 24'h0, 10'h0);
        chk("err", 1, s[1]);
        cmd(3'd5, 2'd0, 24'h0, 10'h1);
        chk("err", 1, s[1]);
        cmd(3'd6, 2'd1, 24'h0, 10'h201);
        chk("err", 1, s[1]);
        chk("frames", f, u_sfpe_dev.n_frame);
        $display("test refuse done");
    endtask : t_refuse

    initial begin
        nrst = 1'b0;
        wb_i = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_erase();
        t_prog();
        t_otp();
        t_refuse();
        finish_test();
    end
endmodule : tb_serial_flash_program_erase
